//--- rtl/far_consts.vh
`ifndef FAR_CONSTS_VH
`define FAR_CONSTS_VH

// ----------------------------------------------------------------
// register map (byte addresses)
// ----------------------------------------------------------------
`define FAR_ADDR_W 8
`define FAR_REG_CTRL 8'h00
`define FAR_REG_ACTION 8'h04
`define FAR_REG_DELAY0 8'h08
`define FAR_REG_STATUS 8'h24

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define FAR_CTRL_LIMIT_LSB 0
`define FAR_CTRL_LIMIT_W 4
`define FAR_CTRL_MODEL_EN 4
`define FAR_CTRL_PTC_EN 5
`define FAR_CTRL_MININT_EN 6
`define FAR_CTRL_HOUR_EN 7
`define FAR_LIMIT_MAX 4'ha
`define FAR_LIMIT_OFF 4'h0

// ----------------------------------------------------------------
// alarm actions, 3 bits per alarm in the action register
// ----------------------------------------------------------------
`define FAR_ACT_W 3
`define FAR_ACT_OFF 3'h0
`define FAR_ACT_WARN 3'h1
`define FAR_ACT_COAST 3'h2
`define FAR_ACT_STOP 3'h3
`define FAR_ACT_BRAKE 3'h4

// ----------------------------------------------------------------
// alarm index assignment
// ----------------------------------------------------------------
`define FAR_AL_THERMAL 3'h0
`define FAR_AL_STARTLIM 3'h1
`define FAR_AL_LOCKROT 3'h2
`define FAR_AL_CURLIM 3'h3
`define FAR_AL_MAXPWR 3'h4
`define FAR_AL_MINPWR 3'h5
`define FAR_AL_EXTERN 3'h6
`define FAR_N_ALARM 7

// ----------------------------------------------------------------
// delay settings (seconds, 0 = off)
// ----------------------------------------------------------------
`define FAR_DLY_W 12
`define FAR_DLY_OFF 12'h000
`define FAR_DLY_MAX 12'he10

// ----------------------------------------------------------------
// status register fields
// ----------------------------------------------------------------
`define FAR_ST_CNT_LSB 0
`define FAR_ST_STATE_LSB 4
`define FAR_ST_IDX_LSB 9
`define FAR_ST_DLY_LSB 12

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define FAR_CLK_PERIOD_NS 50
`define FAR_SECOND_NS 1000000000
`define FAR_QUIET_MIN 10
`define FAR_SEC_PER_MIN 60

`endif

//--- rtl/far_restart_mgr.v
`timescale 1ns/1ps
`include "far_consts.vh"

module far_restart_mgr #(
    parameter N_ALARM = `FAR_N_ALARM,
    parameter TICK_CYCLES = `FAR_SECOND_NS / `FAR_CLK_PERIOD_NS,
    parameter QUIET_S = `FAR_QUIET_MIN * `FAR_SEC_PER_MIN
) (
    // clock and reset
    input wire i_clock,
    input wire i_reset,
    // register port
    input wire [`FAR_ADDR_W-1:0] i_addr,
    input wire [31:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    output reg [31:0] o_rdata,
    // protection detectors
    input wire [N_ALARM-1:0] i_alarm,
    input wire i_model_ok,
    input wire i_ptc_ok,
    input wire i_min_interval_ok,
    input wire i_hour_start_ok,
    input wire i_ext_input_active,
    // commands and control source
    input wire i_start_cmd,
    input wire i_stop_cmd,
    input wire i_manual_reset,
    input wire i_src_local,
    // motor control
    input wire i_stop_done,
    output reg o_stop_req,
    output reg [`FAR_ACT_W-1:0] o_stop_action,
    output reg o_alarm_reset,
    output reg o_restart,
    // status
    output reg o_fault,
    output reg o_lockout,
    output reg o_standby_led
);

    // ----------------------------------------------------------------
    // states and helpers
    // ----------------------------------------------------------------
    // one-hot codes, read back unchanged in the status word
    localparam S_IDLE = 5'b00001;
    localparam S_STOP = 5'b00010;
    localparam S_WAIT = 5'b00100;
    localparam S_DELAY = 5'b01000;
    localparam S_LOCK = 5'b10000;
    localparam ACT_BITS = N_ALARM * `FAR_ACT_W;

    // action field of one alarm
    function [`FAR_ACT_W-1:0] act_of;
        input [ACT_BITS-1:0] acts;
        input [2:0] idx;
        begin
            act_of = acts[idx * `FAR_ACT_W +: `FAR_ACT_W];
        end
    endfunction

    // action that really stops the motor
    function stops_motor;
        input [`FAR_ACT_W-1:0] act;
        begin
            stops_motor = (act != `FAR_ACT_OFF) && (act != `FAR_ACT_WARN);
        end
    endfunction

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    reg [4:0] state_r;
    reg [4:0] state_nxt;
    reg [`FAR_CTRL_LIMIT_W-1:0] limit_r;
    reg model_en_r;
    reg ptc_en_r;
    reg minint_en_r;
    reg hour_en_r;
    reg [ACT_BITS-1:0] action_r;
    reg [`FAR_DLY_W-1:0] delay_r [0:N_ALARM-1];
    reg [3:0] cnt_r;
    reg [2:0] idx_r;
    reg auto_ok_r;
    reg [`FAR_DLY_W-1:0] dly_cnt_r;
    reg [31:0] tick_cnt_r;
    reg tick_r;
    reg [15:0] quiet_r;
    integer k;
    // separate loop index keeps k driven by one process only
    integer j;

    wire limit_on = (limit_r != `FAR_LIMIT_OFF);
    // either event ends a pending restart
    wire abandon = i_stop_cmd | i_src_local;
    wire waiting = state_r[2] | state_r[3];

    // ----------------------------------------------------------------
    // alarm pick: lowest index with a stopping action
    // ----------------------------------------------------------------
    reg hit;
    reg [2:0] hit_idx;
    always @* begin
        hit = 1'b0;
        hit_idx = 3'h0;
        for (k = N_ALARM - 1; k >= 0; k = k - 1) begin
            if (i_alarm[k] && stops_motor(act_of(action_r, k[2:0]))) begin
                hit = 1'b1;
                hit_idx = k[2:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // fault-gone condition per alarm kind
    // ----------------------------------------------------------------
    // rotor, current-limit and power faults are invisible at standstill, so they count as gone
    reg clear_ok;
    always @* begin
        case (idx_r)
            `FAR_AL_THERMAL: clear_ok = (!model_en_r || i_model_ok) && (!ptc_en_r || i_ptc_ok);
            `FAR_AL_STARTLIM: clear_ok = (!minint_en_r || i_min_interval_ok)
                                         && (!hour_en_r || i_hour_start_ok);
            `FAR_AL_LOCKROT: clear_ok = 1'b1;
            `FAR_AL_CURLIM: clear_ok = 1'b1;
            `FAR_AL_MAXPWR: clear_ok = 1'b1;
            `FAR_AL_MINPWR: clear_ok = 1'b1;
            `FAR_AL_EXTERN: clear_ok = i_ext_input_active;
            default: clear_ok = 1'b1;
        endcase
    end

    // ----------------------------------------------------------------
    // sequencer next state
    // ----------------------------------------------------------------
    always @* begin
        state_nxt = state_r;
        case (state_r)
            S_IDLE: begin
                if (hit) begin
                    state_nxt = S_STOP;
                end
            end
            S_STOP: begin
                // delay only counts once the stop action has completed
                if (abandon) begin
                    state_nxt = S_LOCK;
                end else if (i_stop_done) begin
                    state_nxt = auto_ok_r ? S_WAIT : S_LOCK;
                end
            end
            S_WAIT: begin
                if (abandon) begin
                    state_nxt = S_LOCK;
                end else if (clear_ok) begin
                    state_nxt = S_DELAY;
                end
            end
            S_DELAY: begin
                if (abandon) begin
                    state_nxt = S_LOCK;
                end else if (dly_cnt_r == `FAR_DLY_OFF) begin
                    state_nxt = S_IDLE;
                end
            end
            S_LOCK: begin
                state_nxt = S_LOCK;
            end
            default: begin
                state_nxt = S_IDLE;
            end
        endcase
        // manual reset overrides every state, lockout included
        if (i_manual_reset) begin
            state_nxt = S_IDLE;
        end
    end

    wire auto_restart = state_r[3] && (state_nxt == S_IDLE) && !i_manual_reset;

    // ----------------------------------------------------------------
    // one-second tick
    // ----------------------------------------------------------------
    // shared free-running tick, so a delay may run up to one second short
    // the compare uses >= so a corrupted count cannot stall the tick
    always @(posedge i_clock) begin
        if (i_reset) begin
            tick_cnt_r <= 32'h0000_0000;
            tick_r <= 1'b0;
        end else if (tick_cnt_r >= TICK_CYCLES - 1) begin
            tick_cnt_r <= 32'h0000_0000;
            tick_r <= 1'b1;
        end else begin
            tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
            tick_r <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // sequencer registers
    // ----------------------------------------------------------------
    always @(posedge i_clock) begin
        if (i_reset) begin
            state_r <= S_IDLE;
            idx_r <= 3'h0;
            auto_ok_r <= 1'b0;
            dly_cnt_r <= `FAR_DLY_OFF;
        end else begin
            state_r <= state_nxt;
            if (state_r[0] && hit) begin
                idx_r <= hit_idx;
                // decided once per fault, against the count before this restart
                auto_ok_r <= limit_on && !i_src_local && (delay_r[hit_idx] != `FAR_DLY_OFF)
                             && (cnt_r < limit_r);
            end
            if (state_r[2]) begin
                dly_cnt_r <= delay_r[idx_r];
            end else if (state_r[3] && tick_r && dly_cnt_r != `FAR_DLY_OFF) begin
                dly_cnt_r <= dly_cnt_r - 12'h001;
            end
        end
    end

    // ----------------------------------------------------------------
    // attempt counter and quiet timer
    // ----------------------------------------------------------------
    always @(posedge i_clock) begin
        if (i_reset) begin
            cnt_r <= 4'h0;
            quiet_r <= 16'h0000;
        end else begin
            // a clear beats an increment, which beats a quiet decrement
            // the count may still fall in lockout; the manual reset zeroes it anyway
            if (i_manual_reset || i_stop_cmd || i_start_cmd) begin
                cnt_r <= 4'h0;
            end else if (auto_restart) begin
                cnt_r <= cnt_r + 4'h1;
            end else if (tick_r && quiet_r >= QUIET_S && cnt_r != 4'h0) begin
                cnt_r <= cnt_r - 4'h1;
            end
            if (|i_alarm) begin
                quiet_r <= 16'h0000;
            end else if (tick_r) begin
                // restarts from zero at the mark so each further quiet span is measured afresh
                quiet_r <= (quiet_r >= QUIET_S) ? 16'h0000 : quiet_r + 16'h0001;
            end
        end
    end

    // ----------------------------------------------------------------
    // motor control and indicator outputs
    // ----------------------------------------------------------------
    always @(posedge i_clock) begin
        if (i_reset) begin
            o_stop_req <= 1'b0;
            o_stop_action <= `FAR_ACT_OFF;
            o_alarm_reset <= 1'b0;
            o_restart <= 1'b0;
            o_fault <= 1'b0;
            o_lockout <= 1'b0;
            o_standby_led <= 1'b0;
        end else begin
            // a fault seen beside a manual reset is taken on the next idle cycle
            o_stop_req <= state_r[0] && hit && !i_manual_reset;
            if (state_r[0] && hit) begin
                o_stop_action <= act_of(action_r, hit_idx);
            end
            o_alarm_reset <= auto_restart || i_manual_reset;
            o_restart <= auto_restart;
            // fault and lockout follow the next state, so they move with the transition
            o_fault <= !state_nxt[0];
            o_lockout <= state_nxt[4];
            if (waiting) begin
                o_standby_led <= tick_r ? !o_standby_led : o_standby_led;
            end else begin
                o_standby_led <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // register writes
    // ----------------------------------------------------------------
    wire [`FAR_ADDR_W-1:0] dly_off = i_addr - `FAR_REG_DELAY0;
    wire [2:0] dly_idx = dly_off[4:2];
    wire dly_hit = (i_addr >= `FAR_REG_DELAY0) && (dly_off[1:0] == 2'b00)
                   && (dly_off[`FAR_ADDR_W-1:2] < N_ALARM);
    wire [`FAR_CTRL_LIMIT_W-1:0] limit_wr = i_wdata[`FAR_CTRL_LIMIT_LSB +: `FAR_CTRL_LIMIT_W];
    wire [`FAR_DLY_W-1:0] dly_wr = i_wdata[`FAR_DLY_W-1:0];

    always @(posedge i_clock) begin
        if (i_reset) begin
            limit_r <= `FAR_LIMIT_OFF;
            model_en_r <= 1'b0;
            ptc_en_r <= 1'b0;
            minint_en_r <= 1'b0;
            hour_en_r <= 1'b0;
            action_r <= {ACT_BITS{1'b0}};
            for (j = 0; j < N_ALARM; j = j + 1) begin
                delay_r[j] <= `FAR_DLY_OFF;
            end
        end else if (i_wr) begin
            if (i_addr == `FAR_REG_CTRL) begin
                // values above ten saturate rather than wrap
                limit_r <= (limit_wr > `FAR_LIMIT_MAX) ? `FAR_LIMIT_MAX : limit_wr;
                model_en_r <= i_wdata[`FAR_CTRL_MODEL_EN];
                ptc_en_r <= i_wdata[`FAR_CTRL_PTC_EN];
                minint_en_r <= i_wdata[`FAR_CTRL_MININT_EN];
                hour_en_r <= i_wdata[`FAR_CTRL_HOUR_EN];
            end
            if (i_addr == `FAR_REG_ACTION) begin
                action_r <= i_wdata[ACT_BITS-1:0];
            end
            // delay slots freeze while the limit is off, so their settings survive
            if (dly_hit && limit_on) begin
                delay_r[dly_idx] <= (dly_wr > `FAR_DLY_MAX) ? `FAR_DLY_MAX : dly_wr;
            end
        end
    end

    // ----------------------------------------------------------------
    // register reads, one cycle after the strobe
    // ----------------------------------------------------------------
    reg [31:0] rd_mux;
    always @* begin
        rd_mux = 32'h0000_0000;
        if (i_addr == `FAR_REG_CTRL) begin
            rd_mux[`FAR_CTRL_LIMIT_LSB +: `FAR_CTRL_LIMIT_W] = limit_r;
            rd_mux[`FAR_CTRL_MODEL_EN] = model_en_r;
            rd_mux[`FAR_CTRL_PTC_EN] = ptc_en_r;
            rd_mux[`FAR_CTRL_MININT_EN] = minint_en_r;
            rd_mux[`FAR_CTRL_HOUR_EN] = hour_en_r;
        end else if (i_addr == `FAR_REG_ACTION) begin
            rd_mux[ACT_BITS-1:0] = action_r;
        end else if (dly_hit && limit_on) begin
            rd_mux[`FAR_DLY_W-1:0] = delay_r[dly_idx];
        end else if (i_addr == `FAR_REG_STATUS) begin
            rd_mux[`FAR_ST_CNT_LSB +: 4] = cnt_r;
            rd_mux[`FAR_ST_STATE_LSB +: 5] = state_r;
            rd_mux[`FAR_ST_IDX_LSB +: 3] = idx_r;
            rd_mux[`FAR_ST_DLY_LSB +: `FAR_DLY_W] = dly_cnt_r;
        end
    end

    // unmapped addresses and idle cycles read as zero
    always @(posedge i_clock) begin
        if (i_reset) begin
            o_rdata <= 32'h0000_0000;
        end else begin
            o_rdata <= i_rd ? rd_mux : 32'h0000_0000;
        end
    end

endmodule

//--- verif/far_motor_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// detectors and stop control of the motor
// ----------------------------------------
module far_motor_model (
    // clock and reset
    input wire i_clock,
    input wire i_reset,
    // bench control
    input wire [3:0] i_lat,
    input wire [6:0] i_set,
    input wire [6:0] i_clr,
    // manager side
    input wire i_stop_req,
    output reg [6:0] o_alarm,
    output reg o_stop_done
);
    reg [3:0] cnt_r;
    // stop action takes i_lat cycles; rotor, current-limit and power faults vanish once stopped
    always @(posedge i_clock) begin
        if (i_reset) begin
            cnt_r <= 4'h0;
            o_alarm <= 7'h00;
            o_stop_done <= 1'h0;
        end else begin
            o_alarm <= (o_alarm | i_set) & ~i_clr & (o_stop_done ? 7'h43 : 7'h7f);
            o_stop_done <= !i_stop_req && (cnt_r == 4'h1);
            if (i_stop_req) begin
                cnt_r <= i_lat;
            end else if (cnt_r != 4'h0) begin
                cnt_r <= cnt_r - 4'h1;
            end
        end
    end
endmodule

//--- verif/far_restart_properties.sv
`timescale 1ns/1ps
// ----------------------------------------
// port checker for the restart manager
// ----------------------------------------
module far_restart_props (
    // clock and reset
    input wire i_clock,
    input wire i_reset,
    // commands
    input wire i_stop_cmd,
    input wire i_manual_reset,
    input wire i_src_local,
    // motor side
    input wire o_stop_req,
    input wire o_alarm_reset,
    input wire o_restart,
    // status
    input wire o_fault,
    input wire o_lockout,
    input wire o_standby_led
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_reset);
    // done, wait-clear and delay load need three edges at least
    sequence no_restart_s;
        !o_restart [*3];
    endsequence
    // manual reset lands in idle without a restart
    sequence cleared_s;
        o_alarm_reset && !o_restart && !o_fault;
    endsequence
    stop_pulse_a:
        assert property (o_stop_req |=> !o_stop_req) else $error("stop request longer than one cycle");
    stop_fault_a:
        assert property (o_stop_req |-> o_fault) else $error("stop request without fault");
    stop_first_a:
        assert property (o_stop_req |=> no_restart_s) else $error("restart too close to stop request");
    restart_pair_a:
        assert property (o_restart |-> o_alarm_reset) else $error("restart without alarm reset");
    local_block_a:
        assert property (o_restart |-> !$past(i_src_local)) else $error("restart under local control");
    stop_abandon_a:
        assert property (o_restart |-> !$past(i_stop_cmd)) else $error("restart despite stop command");
    manual_clear_a:
        assert property (i_manual_reset && o_fault |=> cleared_s) else $error("manual reset not honoured");
    lockout_hold_a:
        assert property (o_lockout && !i_manual_reset |=> o_lockout) else $error("lockout left without reset");
    led_idle_a:
        assert property (!o_fault && !$past(o_fault) |-> !o_standby_led) else $error("indicator flashing in idle");
    reset_quiet_a:
        assert property ($fell(i_reset) |-> !(o_fault || o_stop_req || o_restart || o_lockout || o_standby_led))
        else $error("outputs active after reset");
endmodule

bind far_restart_mgr far_restart_props u_props (.i_clock(i_clock), .i_reset(i_reset), .i_stop_cmd(i_stop_cmd),
    .i_manual_reset(i_manual_reset), .i_src_local(i_src_local), .o_stop_req(o_stop_req),
    .o_alarm_reset(o_alarm_reset), .o_restart(o_restart), .o_fault(o_fault), .o_lockout(o_lockout),
    .o_standby_led(o_standby_led));

//--- verif/test_far_restart_mgr.sv
`timescale 1ns/1ps
`include "far_consts.vh"
module test_far_restart_mgr;
    reg i_clock = 1'h0, i_reset = 1'h1, i_wr = 1'h0, i_rd = 1'h0, i_src_local = 1'h0;
    reg i_start_cmd = 1'h0, i_stop_cmd = 1'h0, i_manual_reset = 1'h0;
    reg [7:0] i_addr = 8'h00;
    reg [31:0] i_wdata = 32'h0, d;
    reg [4:0] oks = 5'h00;
    reg [3:0] lat = 4'h1;
    reg [6:0] set_m = 7'h00, clr_m = 7'h00;
    reg [2:0] acts [0:6];
    wire [31:0] o_rdata;
    wire [6:0] alarm;
    wire [2:0] o_stop_action;
    wire stop_done, o_stop_req, o_alarm_reset, o_restart, o_fault, o_lockout, o_standby_led;
    integer err_count = 0, num_checks = 0, cyc = 0, i, k, n;
    // short tick and quiet time keep the run brief
    far_restart_mgr #(.TICK_CYCLES(4), .QUIET_S(7)) DUT (.i_clock(i_clock), .i_reset(i_reset), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_alarm(alarm), .i_model_ok(oks[4]),
        .i_ptc_ok(oks[3]), .i_min_interval_ok(oks[2]), .i_hour_start_ok(oks[1]), .i_ext_input_active(oks[0]),
        .i_start_cmd(i_start_cmd), .i_stop_cmd(i_stop_cmd), .i_manual_reset(i_manual_reset),
        .i_src_local(i_src_local), .i_stop_done(stop_done), .o_stop_req(o_stop_req),
        .o_stop_action(o_stop_action), .o_alarm_reset(o_alarm_reset), .o_restart(o_restart),
        .o_fault(o_fault), .o_lockout(o_lockout), .o_standby_led(o_standby_led));
    far_motor_model u_motor (.i_clock(i_clock), .i_reset(i_reset), .i_lat(lat), .i_set(set_m), .i_clr(clr_m),
        .i_stop_req(o_stop_req), .o_alarm(alarm), .o_stop_done(stop_done));
    // ----------------------------------------
    // clock, watchdog and helpers
    // ----------------------------------------
    initial forever #25 i_clock = ~i_clock;
    // a hung handshake must still end in a verdict
    always @(posedge i_clock) begin
        cyc++;
        if (cyc == 6000) begin
            err_count++;
            print_verdict;
        end
    end
    task print_verdict;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            $display("wrong value %s expected %h seen %h", nm, e, g);
            err_count++;
        end
    endtask
    task wr(input [7:0] a, input [31:0] v);
        @(posedge i_clock);
        i_addr <= a;
        i_wdata <= v;
        i_wr <= 1'h1;
        @(posedge i_clock);
        i_wr <= 1'h0;
    endtask
    task rd(input [7:0] a);
        @(posedge i_clock);
        i_addr <= a;
        i_rd <= 1'h1;
        @(posedge i_clock);
        i_rd <= 1'h0;
        #1 d = o_rdata;
    endtask
    task pulse(input [2:0] w);
        @(posedge i_clock);
        {i_start_cmd, i_stop_cmd, i_manual_reset} <= w;
        @(posedge i_clock);
        {i_start_cmd, i_stop_cmd, i_manual_reset} <= 3'h0;
    endtask
    task alm(input [6:0] s, input [6:0] c);
        @(posedge i_clock);
        set_m <= s;
        clr_m <= c;
        @(posedge i_clock);
        set_m <= 7'h00;
        clr_m <= 7'h00;
    endtask
    function automatic logic [31:0] act_word();
        act_word = 32'h0;
        for (int j = 0; j < 7; j++) act_word[3*j +: 3] = acts[j];
    endfunction
    // mode 0 auto, 1 gated by clear condition, 2 lockout, 3 stop while waiting, 4 local while waiting
    task run_fault(input integer idx, input integer mode);
        integer m, led, seen;
        reg last;
        seen = 0;
        led = 0;
        oks <= (mode == 1) ? 5'h00 : 5'h1f;
        alm(7'h01 << idx, 7'h00);
        for (m = 0; m < 8 && o_stop_req !== 1'h1; m++) begin
            @(posedge i_clock);
            #1;
        end
        chk("stop request", 1, o_stop_req);
        chk("stop action", acts[idx], o_stop_action);
        if (mode == 1) begin
            repeat (20) @(posedge i_clock);
            rd(`FAR_REG_STATUS);
            chk("wait state", 5'h04, d[8:4]);
            oks <= 5'h1f;
            alm(7'h00, 7'h01 << idx);
        end
        if (mode >= 3) begin
            repeat (10) @(posedge i_clock);
            if (mode == 3) pulse(3'h2);
            else i_src_local <= 1'h1;
        end
        last = o_standby_led;
        for (m = 0; m < 60 && seen == 0; m++) begin
            @(posedge i_clock);
            #1;
            led += (o_standby_led !== last);
            last = o_standby_led;
            seen = (o_restart === 1'h1);
        end
        if (mode < 2) begin
            chk("restart", 1, seen);
            chk("alarm reset", 1, o_alarm_reset);
            chk("indicator toggles", 1, led > 0);
        end else begin
            chk("restart", 0, seen);
            chk("lockout", 1, o_lockout);
        end
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        for (i = 0; i < 7; i++) acts[i] = 3'h2 + i % 3;
        repeat (5) @(posedge i_clock);
        i_reset <= 1'h0;
        rd(`FAR_REG_STATUS);
        chk("status after reset", 32'h10, d);
        wr(`FAR_REG_CTRL, 32'h0f);
        rd(`FAR_REG_CTRL);
        chk("limit saturated", 32'h0a, d);
        wr(`FAR_REG_CTRL, 32'hf4);
        wr(`FAR_REG_DELAY0, 32'hfa0);
        rd(`FAR_REG_DELAY0);
        chk("delay saturated", 32'he10, d);
        for (i = 0; i < 7; i++) wr(`FAR_REG_DELAY0 + 4 * i, (i == 4) ? 5 : (i == 5) ? 0 : 2);
        wr(`FAR_REG_ACTION, act_word());
        run_fault(2, 0);
        for (k = 0; k < 3; k++) begin
            rd(`FAR_REG_STATUS);
            chk("counter", k + 1, d[3:0]);
            run_fault((k == 2) ? 6 : k, 1);
        end
        rd(`FAR_REG_STATUS);
        chk("counter", 4, d[3:0]);
        lat <= 4'h6;
        run_fault(3, 2);
        pulse(3'h1);
        #1 chk("manual reset", 1, o_alarm_reset);
        rd(`FAR_REG_STATUS);
        chk("counter", 0, d[3:0]);
        lat <= 4'h1;
        run_fault(4, 0);
        run_fault(2, 0);
        rd(`FAR_REG_STATUS);
        chk("counter", 2, d[3:0]);
        repeat (32) @(posedge i_clock);
        rd(`FAR_REG_STATUS);
        chk("counter after quiet", 1, d[3:0]);
        pulse(3'h2);
        rd(`FAR_REG_STATUS);
        chk("counter after stop", 0, d[3:0]);
        run_fault(3, 0);
        pulse(3'h4);
        rd(`FAR_REG_STATUS);
        chk("counter after start", 0, d[3:0]);
        run_fault(4, 3);
        pulse(3'h1);
        run_fault(4, 4);
        pulse(3'h1);
        i_src_local <= 1'h1;
        run_fault(2, 2);
        i_src_local <= 1'h0;
        pulse(3'h1);
        run_fault(5, 2);
        pulse(3'h1);
        // off and warning actions must never stop the motor
        for (k = 0; k < 2; k++) begin
            acts[3] = k;
            wr(`FAR_REG_ACTION, act_word());
            alm(7'h08, 7'h00);
            n = 0;
            repeat (20) begin
                @(posedge i_clock);
                #1 n += (o_stop_req !== 1'h0);
            end
            chk("ignored alarm", 0, n);
            chk("fault", 0, o_fault);
            alm(7'h00, 7'h08);
        end
        wr(`FAR_REG_CTRL, 32'hf0);
        run_fault(2, 2);
        rd(`FAR_REG_DELAY0);
        chk("delay hidden", 0, d);
        print_verdict;
    end
endmodule
